// ===== design/watchdog_with_reset_cause.sv
// Lockable watchdog counting timewheel periods, plus reset-cause record.
// Assumes srst is the warm system reset; cold sources arrive from pins.
`timescale 1ns/10ps
`default_nettype none
module watchdog_with_reset_cause #(
    parameter int TW_W = wdt_pkg::TW_W
) (
    input  wire logic       clock,
    input  wire logic       srst,
    input  wire logic       tick,
    input  wire logic       cold_reset_pin,
    input  wire logic       software_reset_req,
    input  wire logic       watchdog_enable_action,
    input  wire logic [1:0] interval_sel,
    input  wire logic [1:0] low_power_sel,
    input  wire logic       watchdog_feed_action,
    input  wire logic       low_power_active,
    input  wire logic       record_clear,
    input  wire logic       gp_write,
    input  wire logic [1:0] gp_value,
    input  wire logic       lvr_disable_write,
    output logic            system_reset,
    output logic            watchdog_active,
    output logic [1:0]      watchdog_count,
    output logic [3:0]      reset_cause_record_q,
    output logic            low_voltage_reset_control
);
    typedef struct packed {
        logic            cold_m;
        logic            cold_s;
        logic            enabled;
        logic [1:0]      interval;
        logic [1:0]      lp_policy;
        logic [TW_W-1:0] timewheel_counter;
        logic [1:0]      count;
        logic            feed_pend;
        logic            sys_rst;
        logic            lvr_en;
    } state_s;
    state_s s_q, s_d;
    logic [1:0] eff_interval;
    logic       wd_run;
    logic       wd_fire;
    logic [3:0] rec_q;

    // Effective interval and run gate under low power
    always_comb begin
        eff_interval = s_q.interval;
        wd_run = s_q.enabled;
        if (low_power_active && s_q.lp_policy == wdt_pkg::low_power_longest_interval) begin
            eff_interval = wdt_pkg::INTERVAL_LONG;
        end
        if (low_power_active && s_q.lp_policy == wdt_pkg::low_power_disable) begin
            wd_run = 1'b0;
        end
        // One fire per expiry; the pending reset masks a second one
        wd_fire = wd_run && !s_q.sys_rst && s_q.count == wdt_pkg::WD_EXPIRE;
    end

    // Next state
    always_comb begin
        s_d = s_q;
        s_d.cold_m = cold_reset_pin;
        s_d.cold_s = s_q.cold_m;
        s_d.sys_rst = wd_fire || software_reset_req;
        if (lvr_disable_write) begin
            s_d.lvr_en = 1'b0;
        end
        if (tick) begin
            // Free running; a feed never realigns it
            if (s_q.timewheel_counter >= wdt_pkg::period_last(eff_interval)) begin
                s_d.timewheel_counter = '0;
            end else begin
                s_d.timewheel_counter = s_q.timewheel_counter + 1'b1;
            end
        end
        if (watchdog_feed_action) begin
            s_d.feed_pend = 1'b1;
        end
        if (tick && s_q.feed_pend) begin
            s_d.count = '0;
            s_d.feed_pend = watchdog_feed_action;
        end else if (tick && wd_run && s_q.count != wdt_pkg::WD_EXPIRE &&
                     s_q.timewheel_counter >= wdt_pkg::period_last(eff_interval)) begin
            s_d.count = s_q.count + 1'b1;
        end
        // Only the first enable takes effect
        if (watchdog_enable_action && !s_q.enabled) begin
            s_d.interval = interval_sel;
            s_d.lp_policy = low_power_sel;
            s_d.timewheel_counter = '0;
            s_d.count = '0;
            s_d.enabled = 1'b1;
        end
    end

    // Warm or cold reset clears the watchdog; the cold synchroniser keeps running
    always_ff @(posedge clock) begin
        if (srst || s_q.sys_rst || s_q.cold_s) begin
            s_q <= '0;
            s_q.cold_m <= s_d.cold_m;
            s_q.cold_s <= s_d.cold_s;
            s_q.lvr_en <= wdt_pkg::LVR_DEFAULT;
        end else begin
            s_q <= s_d;
        end
    end

    reset_cause_record u_record (
        .clock        (clock),
        .cold_reset   (s_q.cold_s),
        .set_watchdog (wd_fire),
        .set_software (software_reset_req),
        .clear_record (record_clear),
        .gp_write     (gp_write),
        .gp_value     (gp_value),
        .record_q     (rec_q)
    );

    // Registered outputs
    always_ff @(posedge clock) begin
        if (srst) begin
            system_reset <= 1'b0;
            watchdog_active <= 1'b0;
            watchdog_count <= '0;
            reset_cause_record_q <= wdt_pkg::REC_RESET_VAL;
            low_voltage_reset_control <= wdt_pkg::LVR_DEFAULT;
        end else begin
            system_reset <= s_q.sys_rst;
            watchdog_active <= s_q.enabled;
            watchdog_count <= s_q.count;
            reset_cause_record_q <= rec_q;
            low_voltage_reset_control <= s_q.lvr_en;
        end
    end

    a_config_locked: assert property (@(posedge clock) disable iff (srst || s_q.sys_rst)
        s_q.enabled |=> s_q.enabled && $stable(s_q.interval) && $stable(s_q.lp_policy))
        else $error("locked configuration changed");
    a_enable_arms: assert property (@(posedge clock) disable iff (srst || s_q.sys_rst)
        (watchdog_enable_action && !s_q.enabled) |=> s_q.enabled && s_q.count == 2'h0
        && s_q.timewheel_counter == '0 && s_q.interval == $past(interval_sel))
        else $error("enable did not arm");
    a_expiry_resets: assert property (@(posedge clock) disable iff (srst)
        wd_fire |=> s_q.sys_rst ##1 !s_q.enabled)
        else $error("expiry did not reset");
    a_feed_zeroes: assert property (@(posedge clock) disable iff (srst || s_q.sys_rst)
        (tick && s_q.feed_pend && !(watchdog_enable_action && !s_q.enabled)) |=> s_q.count == 2'h0)
        else $error("feed did not zero count");
    a_count_step: assert property (@(posedge clock) disable iff (srst || s_q.sys_rst)
        (!tick && !watchdog_enable_action) |=> $stable(s_q.count))
        else $error("count moved without tick");
    a_lvr_default: assert property (@(posedge clock) s_q.sys_rst |=> s_q.lvr_en)
        else $error("low-voltage default not restored");
    a_lp_disable: assert property (@(posedge clock) disable iff (srst)
        (low_power_active && s_q.lp_policy == wdt_pkg::low_power_disable) |-> !wd_fire)
        else $error("fired while disabled in low power");
    a_out_follow: assert property (@(posedge clock) disable iff (srst)
        s_q.sys_rst |=> system_reset)
        else $error("reset output missing");
    c_enable: cover property (@(posedge clock) watchdog_enable_action && !s_q.enabled);
    c_expire: cover property (@(posedge clock) wd_fire);
    c_feed: cover property (@(posedge clock) tick && s_q.feed_pend && s_q.enabled);
endmodule
`default_nettype wire

// ===== design/wdt_pkg.sv
// Constants for the lockable watchdog with reset-cause record.
// Assumes one 10 MHz clock; the timewheel tick arrives as an enable pulse.
package wdt_pkg;
    localparam int          TW_W          = 10;
    localparam logic [1:0]  WD_EXPIRE     = 2'h3;
    localparam logic [1:0]  INTERVAL_LONG = 2'h3;
    localparam int          REC_WD_BIT    = 0;
    localparam int          REC_SW_BIT    = 1;
    localparam int          REC_GP0_BIT   = 2;
    localparam int          REC_GP1_BIT   = 3;
    localparam logic [3:0]  REC_RESET_VAL = 4'h0;
    localparam logic        LVR_DEFAULT   = 1'b1;

    typedef enum logic [1:0] {
        low_power_keep             = 2'b00,
        low_power_longest_interval = 2'b01,
        low_power_disable          = 2'b10
    } low_power_e;

    // Selected period in timewheel ticks, minus one for compare
    function automatic logic [TW_W-1:0] period_last(input logic [1:0] sel);
        case (sel)
            2'h0:    period_last = 10'h001;
            2'h1:    period_last = 10'h00f;
            2'h2:    period_last = 10'h07f;
            default: period_last = 10'h3ff;
        endcase
    endfunction
endpackage

// ===== design/reset_cause_record.sv
// Reset-cause record that survives watchdog and software resets.
// Assumes cold resets arrive already synchronised to clock.
`timescale 1ns/10ps
`default_nettype none
module reset_cause_record (
    input  wire logic       clock,
    input  wire logic       cold_reset,
    input  wire logic       set_watchdog,
    input  wire logic       set_software,
    input  wire logic       clear_record,
    input  wire logic       gp_write,
    input  wire logic [1:0] gp_value,
    output var  logic [3:0] record_q
);
    typedef struct packed {
        logic [3:0] rec;
    } state_s;
    state_s s_q, s_d;

    // Sets win over a firmware clear
    always_comb begin
        s_d = s_q;
        if (clear_record) begin
            s_d.rec = wdt_pkg::REC_RESET_VAL;
        end
        if (gp_write) begin
            s_d.rec[wdt_pkg::REC_GP1_BIT:wdt_pkg::REC_GP0_BIT] = gp_value;
        end
        if (set_watchdog) begin
            s_d.rec[wdt_pkg::REC_WD_BIT] = 1'b1;
        end
        if (set_software) begin
            s_d.rec[wdt_pkg::REC_SW_BIT] = 1'b1;
        end
    end

    // Of all resets, only a cold reset clears the record
    always_ff @(posedge clock) begin
        if (cold_reset) begin
            s_q <= '{rec: wdt_pkg::REC_RESET_VAL};
        end else begin
            s_q <= s_d;
        end
    end
    assign record_q = s_q.rec;

    a_cold_clears: assert property (@(posedge clock) cold_reset |=> record_q == wdt_pkg::REC_RESET_VAL)
        else $error("record not cleared by cold reset");
    a_wd_flag_set: assert property (@(posedge clock) disable iff (cold_reset)
        set_watchdog |=> record_q[wdt_pkg::REC_WD_BIT])
        else $error("watchdog flag not set");
endmodule
`default_nettype wire

// ===== verif/watchdog_with_reset_cause_tb_top.sv
// Self-checking bench for the lockable watchdog and its reset-cause record.
// Assumes the design package is compiled first; ticks come every cycle.
`timescale 1ns/10ps
`default_nettype none
module watchdog_with_reset_cause_tb_top;
    logic       clock = 1'b0;
    logic       srst = 1'b1;
    logic       tick = 1'b0;
    logic       tick_on = 1'b0;
    logic       cold_reset_pin = 1'b1;
    logic       sw_req = 1'b0;
    logic       en_act = 1'b0;
    logic [1:0] interval_sel = 2'h0;
    logic [1:0] low_power_sel = 2'h0;
    logic       feed = 1'b0;
    logic       low_power_active = 1'b0;
    logic       record_clear = 1'b0;
    logic       gp_write = 1'b0;
    logic [1:0] gp_value = 2'h0;
    logic       lvr_disable_write = 1'b0;
    logic       system_reset;
    logic       watchdog_active;
    logic [1:0] watchdog_count;
    logic [3:0] record;
    logic       lvr_ctl;
    int         errors = 0;
    int         comparisons = 0;
    int         n;

    watchdog_with_reset_cause dut (
        .clock(clock), .srst(srst), .tick(tick), .cold_reset_pin(cold_reset_pin),
        .software_reset_req(sw_req), .watchdog_enable_action(en_act), .interval_sel(interval_sel),
        .low_power_sel(low_power_sel), .watchdog_feed_action(feed), .low_power_active(low_power_active),
        .record_clear(record_clear), .gp_write(gp_write), .gp_value(gp_value),
        .lvr_disable_write(lvr_disable_write), .system_reset(system_reset), .watchdog_active(watchdog_active),
        .watchdog_count(watchdog_count), .reset_cause_record_q(record), .low_voltage_reset_control(lvr_ctl)
    );

    // 100 ns clock and free-running timewheel ticks
    always #50 clock = ~clock;
    always @(negedge clock) tick <= tick_on;

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One-cycle pulse on the chosen action inputs
    task automatic pulse(input logic [5:0] m);
        @(negedge clock);
        {en_act, sw_req, feed, record_clear, gp_write, lvr_disable_write} = m;
        @(negedge clock);
        {en_act, sw_req, feed, record_clear, gp_write, lvr_disable_write} = 6'h00;
    endtask

    task automatic enable(input logic [1:0] iv, input logic [1:0] lp);
        interval_sel = iv;
        low_power_sel = lp;
        pulse(6'h20);
    endtask

    // Bounded wait for a system reset pulse
    task automatic watch(input int lim, output int cnt);
        cnt = 0;
        while (cnt < lim && system_reset !== 1'b1) begin
            @(negedge clock);
            cnt++;
        end
    endtask

    task automatic idle(input int k);
        repeat (k) @(negedge clock);
    endtask

    task automatic final_report;
        if (errors == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    initial begin
        idle(4);
        cold_reset_pin = 1'b0;
        idle(4);
        srst = 1'b0;
        chk("lvr_ctl", lvr_ctl, 1'b1);
        chk("active", watchdog_active, 1'b0);
        tick_on = 1'b1;
        enable(2'h0, 2'h0);
        idle(2);
        chk("active", watchdog_active, 1'b1);
        watch(30, n);
        chk("short expiry", n >= 3 && n <= 14, 1'b1);
        idle(4);
        chk("record", record, 4'h1);
        enable(2'h1, 2'h0);
        idle(3);
        enable(2'h0, 2'h2);
        watch(40, n);
        chk("relock", n, 40);
        for (int i = 0; i < 8; i++) begin
            pulse(6'h08);
            watch(24, n);
            chk("fed", n, 24);
        end
        pulse(6'h08);
        watch(80, n);
        chk("feed window", n >= 31 && n <= 52, 1'b1);
        idle(4);
        pulse(6'h10);
        watch(8, n);
        chk("sw reset", n < 8, 1'b1);
        idle(4);
        chk("record", record, 4'h3);
        gp_value = 2'h2;
        pulse(6'h02);
        idle(4);
        chk("gp bits", record, 4'hb);
        srst = 1'b1;
        idle(2);
        srst = 1'b0;
        idle(4);
        chk("warm keep", record, 4'hb);
        pulse(6'h01);
        idle(4);
        chk("lvr off", lvr_ctl, 1'b0);
        pulse(6'h10);
        idle(6);
        chk("lvr back", lvr_ctl, 1'b1);
        pulse(6'h04);
        idle(4);
        chk("cleared", record, 4'h0);
        pulse(6'h02);
        cold_reset_pin = 1'b1;
        idle(4);
        cold_reset_pin = 1'b0;
        idle(6);
        chk("cold clear", record, 4'h0);
        low_power_active = 1'b1;
        enable(2'h0, 2'h2);
        watch(100, n);
        chk("lp disable", n, 100);
        chk("lp count", watchdog_count, 2'h0);
        srst = 1'b1;
        idle(2);
        srst = 1'b0;
        enable(2'h0, 2'h1);
        watch(100, n);
        chk("lp longest", n, 100);
        watch(3200, n);
        chk("lp longest expiry", n < 3200, 1'b1);
        final_report();
    end
endmodule
`default_nettype wire
